/* File: tks_pkg.sv */
package tks_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int DEBOUNCE_MS = 20;
  localparam int LONG_PRESS_MS = 1000;
  localparam int HOLD_PRESS_MS = 5000;
  localparam int FLASH_HALF_MS = 250;
  localparam int STORE_SHOW_MS = 500;
  localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int LONG_PRESS_CYC = CLK_HZ / 1000 * LONG_PRESS_MS;
  localparam int HOLD_PRESS_CYC = CLK_HZ / 1000 * HOLD_PRESS_MS;
  localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int STORE_SHOW_CYC = CLK_HZ / 1000 * STORE_SHOW_MS;

  // ****************************************
  // menu layout
  // ****************************************
  localparam int SET_ITEMS = 4;
  localparam int REG_ITEMS = 11;
  localparam int SW_COUNT = 8;
  localparam int NUM_ITEMS = SET_ITEMS + 2 + REG_ITEMS;
  localparam logic [4:0] ITEM_SWG = 5'h04;
  localparam logic [4:0] ITEM_MEAS = 5'h05;
  localparam logic [4:0] ITEM_LAST = 5'h10;

  // ****************************************
  // display codes and reset values
  // ****************************************
  localparam logic [3:0] CODE_DASH = 4'ha;
  localparam logic [3:0] CODE_BLANK = 4'hf;
  localparam logic [1:0] DP_LAST = 2'h2;
  localparam logic [2:0] SW_LAST = 3'h7;
  localparam logic [13:0] SET_MAIN_RESET = 14'h0000;
  localparam logic [13:0] SET_SECOND_RESET = 14'h0000;
  localparam logic [7:0] SWG_RESET = 8'h00;

  typedef enum logic [1:0] {
    mode_main,
    mode_sub,
    mode_set,
    mode_store
  } tks_mode_t;

  typedef enum logic [2:0] {
    edit_whole,
    edit_dig0,
    edit_dig1,
    edit_dig2,
    edit_dp,
    edit_switch,
    edit_preview
  } tks_edit_t;

endpackage

/* File: tks_menu.sv */
// Functional notes
// (R1) advance press in main menu steps item, lights its LED, shows its value
// (R2) main menu holds settings, measured current and registers 1..9, 0, A; the code shows B for the last register
// (R3) select held over one second then released enters submenu, red flashes 1
// (R4) select held five seconds in submenu enters setting mode, display flashes
// (R5) select press in setting mode selects rightmost digit, which flashes
// (R6) advance press changes the flashing digit
// (R7) select presses walk right, middle, left digit, then decimal point
// (R8) advance presses move the decimal point while it is selected
// (R9) after the point, select shows whole flashing preview, then edits again
// (R10) both keys together in setting mode store the value, dashes flash once
// (R11) storing returns to the submenu that was active
// (R12) select held five seconds in setting mode leaves without storing
// (R13) advance held one second in submenu position 1 goes to position 2
// (R14) advance press in submenu returns to main menu, value in use shown
// (R15) switchgroup edit shows switch number left, switch state right
// (R16) advance press toggles selected switch between 1 and 0
// (R17) switchgroup checksum starts at 000 with all switches zero
// (R18) select press advances to the next switch number
// (R19) after last switch the checksum of the switch positions is shown
// (R20) keys debounced and timed as short, one second or five seconds
// (R21) simultaneous press wins over pending single-key decisions
`timescale 1ns/1ps

module tks_key #(
  parameter int DEB_CYC = tks_pkg::DEBOUNCE_CYC,
  parameter int LONG_CYC = tks_pkg::LONG_PRESS_CYC,
  parameter int HOLD_CYC = tks_pkg::HOLD_PRESS_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // key
  input wire logic raw_i,
  input wire logic cancel_i,
  // classified events
  output logic down_o,
  output logic short_o,
  output logic long_o,
  output logic hold_o
);

  logic [31:0] deb_cnt;
  logic [31:0] press_cnt;
  logic down_q;
  logic fired;
  logic cancelled;

  // ****************************************
  // debounce
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      down_o <= 1'b0;
      deb_cnt <= 32'h0000_0000;
    end else if (raw_i == down_o) begin
      deb_cnt <= 32'h0000_0000;
    end else if (deb_cnt >= 32'(DEB_CYC - 1)) begin // (R20)
      down_o <= raw_i;
      deb_cnt <= 32'h0000_0000;
    end else begin
      deb_cnt <= deb_cnt + 32'h0000_0001;
    end
  end

  // ****************************************
  // press timing
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      down_q <= 1'b0;
      press_cnt <= 32'h0000_0000;
      fired <= 1'b0;
      cancelled <= 1'b0;
      short_o <= 1'b0;
      long_o <= 1'b0;
      hold_o <= 1'b0;
    end else begin
      down_q <= down_o;
      short_o <= 1'b0;
      long_o <= 1'b0;
      hold_o <= 1'b0;
      if (down_o && !down_q) begin
        press_cnt <= 32'h0000_0000;
        fired <= 1'b0;
        cancelled <= cancel_i;
      end else if (down_o) begin
        if (press_cnt != 32'(HOLD_CYC)) begin
          press_cnt <= press_cnt + 32'h0000_0001;
        end
        if (cancel_i) begin
          cancelled <= 1'b1; // (R21)
        end
        // five-second action fires while held, so release after it is silent
        if (!fired && !cancelled && !cancel_i && press_cnt == 32'(HOLD_CYC - 1)) begin
          hold_o <= 1'b1; // (R20)
          fired <= 1'b1;
        end
      end else if (down_q && !fired && !cancelled) begin
        if (press_cnt >= 32'(LONG_CYC)) begin
          long_o <= 1'b1; // (R20)
        end else begin
          short_o <= 1'b1;
        end
      end
    end
  end

endmodule

module tks_menu #(
  parameter int DEB_CYC = tks_pkg::DEBOUNCE_CYC,
  parameter int LONG_CYC = tks_pkg::LONG_PRESS_CYC,
  parameter int HOLD_CYC = tks_pkg::HOLD_PRESS_CYC,
  parameter int FLASH_CYC = tks_pkg::FLASH_HALF_CYC,
  parameter int STORE_CYC = tks_pkg::STORE_SHOW_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // front-panel keys, high while pressed
  input wire logic key_select_i,
  input wire logic key_advance_i,
  // values shown from elsewhere
  input wire logic [11:0] meas_value_i,
  input wire logic [11:0] reg_value_i,
  // display
  output logic [3:0] green_digit2_o,
  output logic [3:0] green_digit1_o,
  output logic [3:0] green_digit0_o,
  output logic [1:0] green_dp_pos_o,
  output logic green_dp_on_o,
  output logic [3:0] red_digit_o,
  output logic [tks_pkg::NUM_ITEMS-1:0] item_led_o,
  // register selection and store strobe
  output logic [3:0] reg_sel_o,
  output logic store_o
);

  logic sel_down, sel_short, sel_long, sel_hold;
  logic adv_down, adv_short, adv_long, adv_hold;
  logic both_down, both_q, both_p, sel_step, adv_step;
  tks_pkg::tks_mode_t mode;
  tks_pkg::tks_edit_t edit;
  logic [4:0] item;
  logic sub_pos;
  logic [2:0] sw_idx;
  logic [13:0] edit_val;
  logic [7:0] edit_sw;
  logic [13:0] set_main [tks_pkg::SET_ITEMS];
  logic [13:0] set_second [tks_pkg::SET_ITEMS];
  logic [7:0] swg_bank [2];
  logic [31:0] flash_cnt;
  logic flash_on;
  logic [31:0] store_cnt;
  logic [13:0] next_val;
  logic [3:0] next_red;
  logic [3:0] next_d2, next_d1, next_d0;
  logic next_dp_on;
  logic [3:0] next_reg;

  function automatic logic [11:0] to_bcd(input logic [7:0] v);
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] o;
    h = v / 8'h64;
    t = (v % 8'h64) / 8'h0a;
    o = v % 8'h0a;
    return {h[3:0], t[3:0], o[3:0]};
  endfunction

  function automatic logic [3:0] bcd_inc(input logic [3:0] d);
    return (d >= 4'h9) ? 4'h0 : d + 4'h1;
  endfunction

  // ****************************************
  // keys
  // ****************************************
  tks_key #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC), .HOLD_CYC(HOLD_CYC)) u_key_select (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .raw_i(key_select_i),
    .cancel_i(both_down),
    .down_o(sel_down),
    .short_o(sel_short),
    .long_o(sel_long),
    .hold_o(sel_hold)
  );

  tks_key #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC), .HOLD_CYC(HOLD_CYC)) u_key_advance (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .raw_i(key_advance_i),
    .cancel_i(both_down),
    .down_o(adv_down),
    .short_o(adv_short),
    .long_o(adv_long),
    .hold_o(adv_hold)
  );

  assign both_down = sel_down & adv_down; // (R21)
  assign both_p = both_down & ~both_q;
  assign sel_step = sel_short | sel_long;
  assign adv_step = adv_short | adv_long;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      both_q <= 1'b0;
    end else begin
      both_q <= both_down;
    end
  end

  // ****************************************
  // flash and store timers
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flash_cnt <= 32'h0000_0000;
      flash_on <= 1'b1;
    end else if (flash_cnt >= 32'(FLASH_CYC - 1)) begin
      flash_cnt <= 32'h0000_0000;
      flash_on <= ~flash_on;
    end else begin
      flash_cnt <= flash_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      store_cnt <= 32'h0000_0000;
    end else if (mode == tks_pkg::mode_store) begin
      store_cnt <= store_cnt + 32'h0000_0001;
    end else begin
      store_cnt <= 32'h0000_0000;
    end
  end

  // ****************************************
  // menu state machine
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode <= tks_pkg::mode_main;
      edit <= tks_pkg::edit_whole;
      item <= 5'h00;
      sub_pos <= 1'b0;
      sw_idx <= 3'h0;
      edit_val <= 14'h0000;
      edit_sw <= 8'h00;
    end else begin
      case (mode)
        tks_pkg::mode_main: begin
          if (adv_step) begin
            item <= (item == tks_pkg::ITEM_LAST) ? 5'h00 : item + 5'h01; // (R1)
          end else if (sel_long && item <= tks_pkg::ITEM_SWG) begin
            mode <= tks_pkg::mode_sub; // (R3)
            sub_pos <= 1'b0;
          end
        end
        tks_pkg::mode_sub: begin
          if (sel_hold) begin
            mode <= tks_pkg::mode_set; // (R4)
            edit <= tks_pkg::edit_whole;
            sw_idx <= 3'h0;
            edit_sw <= swg_bank[sub_pos];
            if (item < tks_pkg::ITEM_SWG) begin
              edit_val <= sub_pos ? set_second[item[1:0]] : set_main[item[1:0]];
            end
          end else if (adv_long && !sub_pos) begin
            sub_pos <= 1'b1; // (R13)
          end else if (adv_step) begin
            mode <= tks_pkg::mode_main; // (R14)
          end
        end
        tks_pkg::mode_set: begin
          if (both_p) begin
            mode <= tks_pkg::mode_store; // (R10)
          end else if (sel_hold) begin
            mode <= tks_pkg::mode_sub; // (R12)
          end else if (sel_step && item == tks_pkg::ITEM_SWG) begin
            case (edit)
              tks_pkg::edit_switch: begin
                if (sw_idx == tks_pkg::SW_LAST) begin
                  edit <= tks_pkg::edit_preview; // (R19)
                end else begin
                  sw_idx <= sw_idx + 3'h1; // (R18)
                end
              end
              default: begin
                edit <= tks_pkg::edit_switch; // (R15)
                sw_idx <= 3'h0;
              end
            endcase
          end else if (sel_step) begin
            case (edit)
              tks_pkg::edit_dig0: edit <= tks_pkg::edit_dig1; // (R7)
              tks_pkg::edit_dig1: edit <= tks_pkg::edit_dig2; // (R7)
              tks_pkg::edit_dig2: edit <= tks_pkg::edit_dp; // (R7)
              tks_pkg::edit_dp: edit <= tks_pkg::edit_preview; // (R9)
              default: edit <= tks_pkg::edit_dig0; // (R5)
            endcase
          end else if (adv_step) begin
            case (edit)
              tks_pkg::edit_dig0: edit_val[3:0] <= bcd_inc(edit_val[3:0]); // (R6)
              tks_pkg::edit_dig1: edit_val[7:4] <= bcd_inc(edit_val[7:4]); // (R6)
              tks_pkg::edit_dig2: edit_val[11:8] <= bcd_inc(edit_val[11:8]); // (R6)
              tks_pkg::edit_dp: begin
                edit_val[13:12] <= (edit_val[13:12] >= tks_pkg::DP_LAST) ?
                  2'h0 : edit_val[13:12] + 2'h1; // (R8)
              end
              tks_pkg::edit_switch: edit_sw[sw_idx] <= ~edit_sw[sw_idx]; // (R16)
              default: begin
              end
            endcase
          end
        end
        default: begin
          if (store_cnt >= 32'(STORE_CYC - 1)) begin
            mode <= tks_pkg::mode_sub; // (R11)
          end
        end
      endcase
    end
  end

  // ****************************************
  // setting storage
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < tks_pkg::SET_ITEMS; i++) begin
        set_main[i] <= tks_pkg::SET_MAIN_RESET;
        set_second[i] <= tks_pkg::SET_SECOND_RESET;
      end
      swg_bank[0] <= tks_pkg::SWG_RESET; // (R17)
      swg_bank[1] <= tks_pkg::SWG_RESET; // (R17)
      store_o <= 1'b0;
    end else begin
      store_o <= 1'b0;
      if (mode == tks_pkg::mode_set && both_p) begin
        store_o <= 1'b1; // (R10)
        if (item == tks_pkg::ITEM_SWG) begin
          swg_bank[sub_pos] <= edit_sw;
        end else if (sub_pos) begin
          set_second[item[1:0]] <= edit_val;
        end else begin
          set_main[item[1:0]] <= edit_val;
        end
      end
    end
  end

  // ****************************************
  // display composition
  // ****************************************
  always_comb begin
    next_val = 14'h0000;
    next_red = tks_pkg::CODE_BLANK;
    next_reg = 4'h0;
    if (item > tks_pkg::ITEM_MEAS) begin
      next_reg = 4'(item - tks_pkg::ITEM_MEAS - 5'h01);
    end
    case (mode)
      tks_pkg::mode_main: begin
        if (item < tks_pkg::ITEM_SWG) begin
          next_val = set_main[item[1:0]]; // (R14)
        end else if (item == tks_pkg::ITEM_SWG) begin
          next_val = {2'h0, to_bcd(swg_bank[0])};
        end else if (item == tks_pkg::ITEM_MEAS) begin
          next_val = {2'h0, meas_value_i}; // (R2)
        end else begin
          next_val = {2'h0, reg_value_i}; // (R2)
          // registers read 1..9, then 0, then B
          next_red = (next_reg == 4'h9) ? 4'h0 : next_reg + 4'h1;
        end
      end
      tks_pkg::mode_sub: begin
        if (item == tks_pkg::ITEM_SWG) begin
          next_val = {2'h0, to_bcd(swg_bank[sub_pos])};
        end else if (item < tks_pkg::ITEM_SWG) begin
          next_val = sub_pos ? set_second[item[1:0]] : set_main[item[1:0]];
        end
        next_red = flash_on ? {3'h0, sub_pos} + 4'h1 : tks_pkg::CODE_BLANK; // (R3)
      end
      tks_pkg::mode_set: begin
        next_val = (item == tks_pkg::ITEM_SWG) ? {2'h0, to_bcd(edit_sw)} : edit_val;
        next_red = {3'h0, sub_pos} + 4'h1;
      end
      default: begin
        next_red = {3'h0, sub_pos} + 4'h1; // (R10)
      end
    endcase
  end

  always_comb begin
    next_d2 = next_val[11:8];
    next_d1 = next_val[7:4];
    next_d0 = next_val[3:0];
    next_dp_on = (item != tks_pkg::ITEM_SWG) && (item <= tks_pkg::ITEM_MEAS);
    if (mode == tks_pkg::mode_store) begin
      next_d2 = tks_pkg::CODE_DASH; // (R10)
      next_d1 = tks_pkg::CODE_DASH;
      next_d0 = tks_pkg::CODE_DASH;
      next_dp_on = 1'b0;
    end else if (mode == tks_pkg::mode_set) begin
      if (edit == tks_pkg::edit_switch) begin
        next_d2 = {1'b0, sw_idx} + 4'h1; // (R15)
        next_d1 = tks_pkg::CODE_BLANK;
        next_d0 = {3'h0, edit_sw[sw_idx]};
        if (!flash_on) begin
          next_d0 = tks_pkg::CODE_BLANK;
        end
      end else if (!flash_on) begin
        case (edit)
          tks_pkg::edit_dig0: next_d0 = tks_pkg::CODE_BLANK; // (R5)
          tks_pkg::edit_dig1: next_d1 = tks_pkg::CODE_BLANK; // (R7)
          tks_pkg::edit_dig2: next_d2 = tks_pkg::CODE_BLANK; // (R7)
          tks_pkg::edit_dp: next_dp_on = 1'b0; // (R8)
          default: begin
            // whole display flashes on entry and in preview
            next_d2 = tks_pkg::CODE_BLANK; // (R4)
            next_d1 = tks_pkg::CODE_BLANK; // (R9)
            next_d0 = tks_pkg::CODE_BLANK;
            next_dp_on = 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      green_digit2_o <= tks_pkg::CODE_BLANK;
      green_digit1_o <= tks_pkg::CODE_BLANK;
      green_digit0_o <= tks_pkg::CODE_BLANK;
      green_dp_pos_o <= 2'h0;
      green_dp_on_o <= 1'b0;
      red_digit_o <= tks_pkg::CODE_BLANK;
      item_led_o <= '0;
      reg_sel_o <= 4'h0;
    end else begin
      green_digit2_o <= next_d2;
      green_digit1_o <= next_d1;
      green_digit0_o <= next_d0;
      green_dp_pos_o <= next_val[13:12];
      green_dp_on_o <= next_dp_on;
      red_digit_o <= next_red;
      item_led_o <= '0;
      item_led_o[item] <= 1'b1; // (R1)
      reg_sel_o <= next_reg;
    end
  end

endmodule

/* File: tks_menu_asserts.sv */
`timescale 1ns/1ps

// ****************************************
// port checker of the menu
// ****************************************
module tks_menu_chk #(
  parameter int DEB_CYC = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // keys and shown values
  input wire logic key_select_i,
  input wire logic key_advance_i,
  input wire logic [11:0] meas_value_i,
  // display
  input wire logic [3:0] green_digit1_o,
  input wire logic [3:0] green_digit0_o,
  input wire logic [1:0] green_dp_pos_o,
  input wire logic [3:0] red_digit_o,
  input wire logic [tks_pkg::NUM_ITEMS-1:0] item_led_o,
  input wire logic [3:0] reg_sel_o,
  input wire logic store_o
);
  // release, debounce, pulse, state, output, plus slack
  localparam int ADV_LAG = DEB_CYC + 8;
  // joint press: debounce, edge, store pulse, plus slack
  localparam int BOTH_LAG = DEB_CYC + 24;
  int up_cnt;
  int adv_age;
  int both_age;
  int dash_age;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  // $past and $stable see reset values for the first edges
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      up_cnt <= 0;
    end else if (up_cnt < 3) begin
      up_cnt <= up_cnt + 1;
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      adv_age <= 1000;
    end else if (key_advance_i) begin
      adv_age <= 0;
    end else if (adv_age < 1000) begin
      adv_age <= adv_age + 1;
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      both_age <= 1000;
    end else if (key_select_i && key_advance_i) begin
      both_age <= 0;
    end else if (both_age < 1000) begin
      both_age <= both_age + 1;
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dash_age <= 1000;
    end else if (green_digit1_o == tks_pkg::CODE_DASH) begin
      dash_age <= 0;
    end else if (dash_age < 1000) begin
      dash_age <= dash_age + 1;
    end
  end

  a_store_one_cycle: assert property (store_o |=> !store_o)
    else $error("store strobe longer than one cycle");
  a_store_after_both: assert property (store_o |-> both_age <= BOTH_LAG)
    else $error("store without a joint key press");
  a_store_shows_dash: assert property (
    store_o |-> (dash_age <= 8 or ##[0:8] (green_digit1_o == tks_pkg::CODE_DASH)))
    else $error("store without dashes on display");
  a_led_needs_advance: assert property (
    up_cnt == 3 && $changed(item_led_o) |-> adv_age <= ADV_LAG)
    else $error("item changed without advance key");
  a_led_one_hot: assert property (up_cnt == 3 |-> $onehot(item_led_o))
    else $error("item leds not one-hot");
  a_reg_sel_range: assert property (reg_sel_o <= 4'ha)
    else $error("register index out of range");
  a_dp_pos_range: assert property (green_dp_pos_o <= tks_pkg::DP_LAST)
    else $error("decimal point position out of range");
  a_digit_code_legal: assert property (
    green_digit0_o <= 4'h9 || green_digit0_o == tks_pkg::CODE_DASH ||
    green_digit0_o == tks_pkg::CODE_BLANK)
    else $error("illegal digit code");
  a_meas_shown: assert property (
    up_cnt == 3 && item_led_o[tks_pkg::ITEM_MEAS] && item_led_o == $past(item_led_o, 2) &&
    $stable(meas_value_i) |-> green_digit0_o == meas_value_i[3:0])
    else $error("measured value not on display");

  c_store: cover property (store_o);
  c_second_pos: cover property (red_digit_o == 4'h2);
  c_swg_sub: cover property (item_led_o[tks_pkg::ITEM_SWG] && red_digit_o == 4'h1);
endmodule

bind tks_menu tks_menu_chk #(.DEB_CYC(DEB_CYC)) chk_u (
  .clk_sys_i(clk_sys_i),
  .resetn_i(resetn_i),
  .key_select_i(key_select_i),
  .key_advance_i(key_advance_i),
  .meas_value_i(meas_value_i),
  .green_digit1_o(green_digit1_o),
  .green_digit0_o(green_digit0_o),
  .green_dp_pos_o(green_dp_pos_o),
  .red_digit_o(red_digit_o),
  .item_led_o(item_led_o),
  .reg_sel_o(reg_sel_o),
  .store_o(store_o)
);

/* File: tks_operator.sv */
`timescale 1ns/1ps

// ****************************************
// operator at the two keys
// ****************************************
module tks_operator #(
  parameter int GAP = 16
) (
  // clock
  input wire logic clk_sys_i,
  // keys, high while pressed
  output logic key_select_o,
  output logic key_advance_o
);
  // released keys read low, as with a pull-down
  initial begin
    key_select_o = 1'b0;
    key_advance_o = 1'b0;
  end

  // a joint press moves both keys at once; the gap lets the panel settle
  task automatic press(input logic sel, input logic adv, input int n);
    @(negedge clk_sys_i);
    key_select_o = sel;
    key_advance_o = adv;
    repeat (n) @(negedge clk_sys_i);
    key_select_o = 1'b0;
    key_advance_o = 1'b0;
    repeat (GAP) @(negedge clk_sys_i);
  endtask
endmodule

/* File: test_two_key_setting_menu.sv */
`timescale 1ns/1ps

// ****************************************
// bench
// ****************************************
module test_two_key_setting_menu;
  logic clk_sys_i;
  logic resetn_i;
  logic key_select_i;
  logic key_advance_i;
  logic [11:0] meas_value_i;
  logic [11:0] reg_value_i;
  logic [3:0] green_digit2_o;
  logic [3:0] green_digit1_o;
  logic [3:0] green_digit0_o;
  logic [1:0] green_dp_pos_o;
  logic green_dp_on_o;
  logic [3:0] red_digit_o;
  logic [tks_pkg::NUM_ITEMS-1:0] item_led_o;
  logic [3:0] reg_sel_o;
  logic store_o;
  int failures = 0;
  int n_checks = 0;
  int n_store = 0;

  assign reg_value_i = {8'h45, reg_sel_o};

  tks_menu #(.DEB_CYC(4), .LONG_CYC(20), .HOLD_CYC(60), .FLASH_CYC(3), .STORE_CYC(5)) dut_u (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .key_select_i(key_select_i),
    .key_advance_i(key_advance_i),
    .meas_value_i(meas_value_i),
    .reg_value_i(reg_value_i),
    .green_digit2_o(green_digit2_o),
    .green_digit1_o(green_digit1_o),
    .green_digit0_o(green_digit0_o),
    .green_dp_pos_o(green_dp_pos_o),
    .green_dp_on_o(green_dp_on_o),
    .red_digit_o(red_digit_o),
    .item_led_o(item_led_o),
    .reg_sel_o(reg_sel_o),
    .store_o(store_o)
  );

  tks_operator op_u (
    .clk_sys_i(clk_sys_i),
    .key_select_o(key_select_i),
    .key_advance_o(key_advance_i)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // sampled mid-cycle, where the one-cycle strobe has settled
  always @(negedge clk_sys_i) begin
    if (store_o === 1'b1) begin
      n_store++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // flashing fields blank every few cycles, so wait for a lit phase
  task automatic see(input int f, input logic [3:0] e);
    logic [3:0] v;
    v = 4'hf;
    for (int i = 0; i < 10 && v === 4'hf; i++) begin
      @(negedge clk_sys_i);
      case (f)
        0: v = green_digit0_o;
        1: v = green_digit1_o;
        2: v = green_digit2_o;
        default: v = red_digit_o;
      endcase
    end
    chk(32'(v), 32'(e));
  endtask

  // short 8, long 30, hold 75 cycles against debounce 4, long 20, hold 60
  task automatic sel(input int n);
    op_u.press(1'b1, 1'b0, n);
  endtask
  task automatic adv(input int n);
    op_u.press(1'b0, 1'b1, n);
  endtask

  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic t_edit_store;
    int s0;
    s0 = n_store;
    sel(30);
    see(3, 4'h1);
    sel(75);
    see(0, 4'h0);
    sel(8);
    repeat (3) adv(8);
    see(0, 4'h3);
    sel(8);
    adv(8);
    see(1, 4'h1);
    sel(8);
    repeat (2) adv(8);
    see(2, 4'h2);
    sel(8);
    adv(8);
    chk(32'(green_dp_pos_o), 32'h1);
    sel(8);
    sel(8);
    adv(8);
    see(0, 4'h4);
    repeat (4) sel(8);
    op_u.press(1'b1, 1'b1, 12);
    chk(32'(n_store - s0), 32'h1);
    see(3, 4'h1);
    see(0, 4'h4);
    see(2, 4'h2);
  endtask

  task automatic t_abandon;
    int s0;
    s0 = n_store;
    sel(75);
    sel(8);
    adv(8);
    see(0, 4'h5);
    sel(75);
    repeat (8) begin
      @(negedge clk_sys_i);
      chk(32'(green_digit0_o), 32'h4);
    end
    chk(32'(n_store - s0), 32'h0);
  endtask

  task automatic t_sub_nav;
    adv(30);
    see(3, 4'h2);
    see(0, 4'h0);
    adv(8);
    chk(32'(red_digit_o), 32'hf);
    chk(32'(item_led_o), 32'h1);
    chk(32'(green_dp_on_o), 32'h1);
    see(0, 4'h4);
  endtask

  task automatic t_switchgroup;
    int s0;
    s0 = n_store;
    repeat (4) adv(8);
    chk(32'(item_led_o), 32'h10);
    chk(32'({green_digit2_o, green_digit1_o, green_digit0_o}), 32'h000);
    sel(30);
    sel(75);
    sel(8);
    see(2, 4'h1);
    see(0, 4'h0);
    adv(8);
    see(0, 4'h1);
    sel(8);
    see(2, 4'h2);
    see(0, 4'h0);
    sel(8);
    adv(8);
    see(2, 4'h3);
    see(0, 4'h1);
    repeat (6) sel(8);
    see(0, 4'h5);
    see(1, 4'h0);
    op_u.press(1'b1, 1'b1, 12);
    chk(32'(n_store - s0), 32'h1);
    see(0, 4'h5);
  endtask

  task automatic t_main_items;
    adv(8);
    chk(32'(item_led_o), 32'h10);
    adv(8);
    see(0, 4'h3);
    see(1, 4'h2);
    @(negedge clk_sys_i);
    meas_value_i = 12'h0987;
    repeat (2) @(negedge clk_sys_i);
    chk(32'(green_digit0_o), 32'h7);
    adv(8);
    chk(32'(item_led_o), 32'h40);
    chk(32'(reg_sel_o), 32'h0);
    chk(32'(green_dp_on_o), 32'h0);
    see(1, 4'h5);
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys_i);
    failures++;
    wrap_up();
  end

  initial begin
    meas_value_i = 12'h0123;
    resetn_i = 1'b0;
    repeat (10) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk(32'(item_led_o), 32'h1);
    chk(32'({green_digit2_o, green_digit1_o, green_digit0_o}), 32'h000);
    t_edit_store();
    t_abandon();
    t_sub_nav();
    t_switchgroup();
    t_main_items();
    wrap_up();
  end
endmodule
